// ---- verilog/iscm_defines.vh ----
// Purpose: Constants for the configuration and shared-memory control bank
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
`ifndef ISCM_DEFINES_VH
`define ISCM_DEFINES_VH
// Register byte offsets
`define ISCM_OFF_CONFIG 4'h0
`define ISCM_OFF_SLOT 4'h4
`define ISCM_OFF_SMC1 4'h8
`define ISCM_OFF_SMC2 4'hC
// Configuration register fields
`define ISCM_CFG_BOOT_LSB 0
`define ISCM_CFG_BOOT_MSB 3
`define ISCM_CFG_COMPAT 4
`define ISCM_CFG_INTMODE 5
`define ISCM_CFG_CLKSRC 6
`define ISCM_CFG_LOCK 7
// Shared memory control one fields
`define ISCM_SMC1_BASE_LSB 0
`define ISCM_SMC1_BASE_MSB 5
`define ISCM_SMC1_ENABLE 6
`define ISCM_SMC1_RESET 7
// Shared memory control two fields
`define ISCM_SMC2_BASE_MSB 4
// Reset values
`define ISCM_RST_BYTE 8'h00
`define ISCM_RST_BASE_HI 5'h00
// AXI responses
`define ISCM_RESP_OKAY 2'h0
`define ISCM_RESP_SLVERR 2'h2
// Address slices
`define ISCM_ADDR_HI 23
`define ISCM_ADDR_LO 13
`endif

// ---- verilog/iscm_bank.v ----
// Purpose: Configuration, slot sense and shared-memory control registers
// Assumes: aclk 25 MHz, synchronous active-low reset, AXI4-Lite slave
// Notes: Upper register bits read as zero
//   Config register takes the strap value while reset is held
//   Writes and reads run on separate channels and may overlap
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`include "iscm_defines.vh"
`timescale 1ns/1ps
`default_nettype none

// Register map, one byte in bits 7:0 of each 32-bit word
//   0x0 configuration: boot window 3:0, compat 4, interrupt mode 5,
//       clock source 6, lock 7
//   0x4 slot sense, read only: bit 0 follows the slot width pin
//   0x8 control one: window base low 5:0, window enable 6, core reset 7
//   0xC control two: window base high 4:0
// Write responses
//   OKAY for an accepted write
//   SLVERR for a locked, read-only or unmapped target; nothing changes
// Timing on the register bus
//   bvalid rises one edge after both write halves are held
//   rvalid rises on the edge that takes the read address
//   Each answer stands until its ready is sampled high
// Host side
//   Decode results and control outputs follow their inputs by one edge
//   The boot window only answers reads; buffer decode covers both
module iscm_bank (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire awvalid,
  output reg awready,
  input wire [3:0] awaddr,
  // AXI4-Lite write data
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read address
  input wire arvalid,
  output reg arready,
  input wire [3:0] araddr,
  // AXI4-Lite read data
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Board straps and EEPROM image
  input wire [7:0] switch_config,
  input wire eeprom_config_enable,
  input wire [7:0] eeprom_config,
  input wire slot_width_pin,
  // Host memory cycle
  input wire host_mem_cycle,
  input wire host_mem_read,
  input wire [23:0] host_addr,
  input wire [7:0] memory_data_pins,
  // Decoded results
  output reg buffer_select,
  output reg boot_rom_read,
  output reg [7:0] host_data_out,
  output reg host_data_oe,
  // Core controls
  output reg core_reset,
  output reg core_clock_source,
  output reg interrupt_drive_select,
  output reg compat_map_select,
  output reg soft_config_lock
);

  // Configuration register: boot window, compat, interrupt mode, clock, lock
  reg [7:0] config_q;
  // Shared memory control one: base low bits, window enable, core reset
  reg [7:0] smc1_q;
  // Shared memory control two: base high bits only
  reg [4:0] smc2_q;
  // Write address taken, waiting for its data
  reg aw_held_q;
  // Write data taken, waiting for its address
  reg w_held_q;
  // Captured write address
  reg [3:0] aw_addr_q;
  // Captured low byte of the write data
  reg [7:0] w_data_q;
  // Captured strobe of byte lane zero
  reg w_strb_q;
  // Read inside the selected boot window
  reg boot_hit;
  // Boot ROM window select field
  wire [3:0] boot_rom_select;
  // Window base halves as programmed
  wire [5:0] window_base_low;
  wire [4:0] window_base_high;
  // Memory window enable bit
  wire memory_window_enable;
  // Host address falls inside the enabled window
  wire win_hit;

  // Boot ROM window match for the selected size
  // Only address bits above the window size are compared
  function boot_match;
    input [3:0] sel;
    input [23:0] a;
    begin
      case (sel)
        // Sixteen kilobyte windows
        4'h2: boot_match = (a[23:14] == 10'h030);
        4'h3: boot_match = (a[23:14] == 10'h031);
        4'h4: boot_match = (a[23:14] == 10'h032);
        4'h5: boot_match = (a[23:14] == 10'h033);
        4'h6: boot_match = (a[23:14] == 10'h034);
        4'h7: boot_match = (a[23:14] == 10'h035);
        4'h8: boot_match = (a[23:14] == 10'h036);
        4'h9: boot_match = (a[23:14] == 10'h037);
        // Thirty-two kilobyte windows
        4'hA: boot_match = (a[23:15] == 9'h018);
        4'hB: boot_match = (a[23:15] == 9'h019);
        4'hC: boot_match = (a[23:15] == 9'h01A);
        4'hD: boot_match = (a[23:15] == 9'h01B);
        // Sixty-four kilobyte windows
        4'hE: boot_match = (a[23:16] == 8'h0C);
        4'hF: boot_match = (a[23:16] == 8'h0D);
        // No boot ROM fitted
        default: boot_match = 1'b0;
      endcase
    end
  endfunction

  // Boot window select, memory window base and enable
  assign boot_rom_select = config_q[`ISCM_CFG_BOOT_MSB:`ISCM_CFG_BOOT_LSB];
  assign window_base_low = smc1_q[`ISCM_SMC1_BASE_MSB:`ISCM_SMC1_BASE_LSB];
  assign window_base_high = smc2_q;
  assign memory_window_enable = smc1_q[`ISCM_SMC1_ENABLE];
  // window match
  // Compared every cycle; buffer_select registers the result
  assign win_hit = memory_window_enable &&
    (host_addr[`ISCM_ADDR_HI:`ISCM_ADDR_LO] == {window_base_high, window_base_low});

  // Boot decode only on reads
  // A host write never reaches the boot ROM
  always @* begin
    boot_hit = host_mem_cycle && host_mem_read && boot_match(boot_rom_select, host_addr);
  end

  // Write channel: accept address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      // Both channels ready to take a request
      awready <= 1'b1;
      wready <= 1'b1;
      // No response pending
      bvalid <= 1'b0;
      bresp <= `ISCM_RESP_OKAY;
      // Capture registers empty
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= `ISCM_RST_BYTE;
      w_strb_q <= 1'b0;
      // Configuration starts from the board straps
      config_q <= switch_config;
      smc1_q <= `ISCM_RST_BYTE;
      smc2_q <= `ISCM_RST_BASE_HI;
    end else begin
      // Loaded on every edge while the enable stays high
      // EEPROM override ignores lock
      if (eeprom_config_enable) begin
        config_q <= eeprom_config;
      end
      // Address capture
      // Address waits here until its data arrives
      if (awvalid && awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= awaddr;
        awready <= 1'b0;
      end
      // Data capture, low byte lane only
      // Upper lanes carry no register bits
      if (wvalid && wready) begin
        w_held_q <= 1'b1;
        w_data_q <= wdata[7:0];
        w_strb_q <= wstrb[0];
        wready <= 1'b0;
      end
      // Perform write once both halves held
      // A pending response holds off the next update
      if (aw_held_q && w_held_q && !bvalid) begin
        // Answer OKAY unless a refusal below overrides it
        bvalid <= 1'b1;
        bresp <= `ISCM_RESP_OKAY;
        case (aw_addr_q)
          // Configuration register
          `ISCM_OFF_CONFIG: begin
            if (config_q[`ISCM_CFG_LOCK] || eeprom_config_enable) begin
              bresp <= `ISCM_RESP_SLVERR;
            end else if (w_strb_q) begin
              // Lane zero strobe gates the update
              config_q <= w_data_q;
            end
          end
          // Slot sense register
          `ISCM_OFF_SLOT: begin
            // Read-only register
            bresp <= `ISCM_RESP_SLVERR;
          end
          // Shared memory control one
          `ISCM_OFF_SMC1: begin
            if (w_strb_q) begin
              // Enable and core reset change together with the base
              smc1_q <= w_data_q;
            end
          end
          // Shared memory control two
          `ISCM_OFF_SMC2: begin
            if (w_strb_q) begin
              // Upper bits of the byte are dropped
              smc2_q <= w_data_q[`ISCM_SMC2_BASE_MSB:0];
            end
          end
          // Offset outside the map
          default: begin
            bresp <= `ISCM_RESP_SLVERR;
          end
        endcase
      end
      // Response taken, reopen channels
      // Held flags drop so a new request can be taken
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read channel: one cycle answer after address taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      // Address channel open
      arready <= 1'b1;
      // Nothing to return yet
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `ISCM_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        // Answer stands from the next edge
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `ISCM_RESP_OKAY;
        case (araddr)
          `ISCM_OFF_CONFIG: begin
            // Readable even while locked
            rdata <= {24'h000000, config_q};
          end
          `ISCM_OFF_SLOT: begin
            rdata <= {31'h00000000, slot_width_pin};
          end
          `ISCM_OFF_SMC1: begin
            // Control one as last written
            rdata <= {24'h000000, smc1_q};
          end
          `ISCM_OFF_SMC2: begin
            // Control two, upper bits zero
            rdata <= {27'h0000000, smc2_q};
          end
          default: begin
            // Unmapped offset: zero data with an error
            rdata <= 32'h0000_0000;
            rresp <= `ISCM_RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        // Data taken, reopen the address channel
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Host side decode and control outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      // Nothing decoded, bus not driven
      buffer_select <= 1'b0;
      boot_rom_read <= 1'b0;
      host_data_out <= `ISCM_RST_BYTE;
      host_data_oe <= 1'b0;
      // Core runs, controls at their defaults
      core_reset <= 1'b0;
      core_clock_source <= 1'b0;
      interrupt_drive_select <= 1'b0;
      compat_map_select <= 1'b0;
      soft_config_lock <= 1'b0;
    end else begin
      // Decode results follow the host cycle by one edge
      // buffer access only when enabled
      buffer_select <= host_mem_cycle && win_hit;
      // boot ROM byte onto system bus
      boot_rom_read <= boot_hit;
      host_data_oe <= boot_hit;
      // Data bus shows zero when not driven
      host_data_out <= boot_hit ? memory_data_pins : `ISCM_RST_BYTE;
      core_reset <= smc1_q[`ISCM_SMC1_RESET];
      core_clock_source <= config_q[`ISCM_CFG_CLKSRC];
      interrupt_drive_select <= config_q[`ISCM_CFG_INTMODE];
      compat_map_select <= config_q[`ISCM_CFG_COMPAT];
      soft_config_lock <= config_q[`ISCM_CFG_LOCK];
    end
  end

endmodule // iscm_bank
`default_nettype wire

// ---- bench/iscm_bank_properties.sv ----
// Purpose: Port checks for iscm_bank
// Assumes: One clock, sync active-low reset
// Notes: Bound after endmodule
`timescale 1ns/1ps
`default_nettype none
module iscm_bank_properties (
  input wire aclk, aresetn, awvalid, awready, wvalid, wready, bvalid,
  input wire arvalid, arready, slot_width_pin, eeprom_config_enable, rvalid,
  input wire host_mem_cycle, host_mem_read, buffer_select, boot_rom_read,
  input wire host_data_oe, core_reset, core_clock_source, interrupt_drive_select,
  input wire compat_map_select, soft_config_lock,
  input wire [3:0] awaddr, araddr,
  input wire [31:0] wdata, rdata,
  input wire [1:0] bresp,
  input wire [7:0] eeprom_config, memory_data_pins, host_data_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Handshakes
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  property p_eep; eeprom_config_enable |-> ##2 {soft_config_lock, core_clock_source,
    interrupt_drive_select, compat_map_select} == $past(eeprom_config[7:4], 2); endproperty
  a_eep: assert property (p_eep) else $error("eeprom");
  property p_slot; arvalid && arready && araddr == 4'h4 |=>
    rvalid && rdata[0] == $past(slot_width_pin); endproperty
  a_slot: assert property (p_slot) else $error("slot");
  property p_lock; aw_hs && awaddr == 4'h0 && soft_config_lock |->
    ##[1:3] bvalid && bresp == 2'h2; endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_ro; aw_hs && awaddr == 4'h4 |-> ##[1:3] bvalid && bresp == 2'h2; endproperty
  a_ro: assert property (p_ro) else $error("ro");
  property p_buf; buffer_select |-> $past(host_mem_cycle); endproperty
  a_buf: assert property (p_buf) else $error("buf");
  property p_boot; boot_rom_read |-> host_data_oe && $past(host_mem_read)
    && host_data_out == $past(memory_data_pins); endproperty
  a_boot: assert property (p_boot) else $error("boot");
  property p_rst; aw_hs && w_hs && awaddr == 4'h8 && wdata[7] |-> ##[1:4] core_reset; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_hold; $fell(core_reset) && $past(aresetn) |->
    $past(w_hs, 1) || $past(w_hs, 2) || $past(w_hs, 3); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_resp; aw_hs && w_hs |-> ##[1:2] bvalid; endproperty
  a_resp: assert property (p_resp) else $error("resp");
  c_buf: cover property (buffer_select);
  c_boot: cover property (boot_rom_read);
  c_lock: cover property (soft_config_lock && bvalid && bresp == 2'h2);
endmodule // iscm_bank_properties
bind iscm_bank iscm_bank_properties u_props (.*);
`default_nettype wire

// ---- bench/iscm_host.sv ----
// Purpose: Host software model, AXI4-Lite master
// Assumes: Tasks entered just after a clock edge
// Notes: Waits for answers with no fixed latency
`timescale 1ns/1ps
`default_nettype none
module iscm_host (
  input wire logic aclk, awready, wready, bvalid, arready, rvalid,
  input wire logic [1:0] bresp,
  input wire logic [31:0] rdata,
  output logic awvalid, wvalid, bready, arvalid, rready,
  output logic [3:0] awaddr, araddr, wstrb,
  output logic [31:0] wdata
);
  // Idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
  end
  // Write one byte, return response
  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    {aw_ok, w_ok} = 2'b00;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, 24'h000000, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Read one word
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    v = rdata;
    rready <= 1'b0;
  endtask
endmodule // iscm_host
`default_nettype wire

// ---- bench/isa_config_shared_memory_ctrl_bench.sv ----
// Purpose: Self-checking bench for iscm_bank
// Assumes: 25 MHz aclk, reset held 16 cycles
// Notes: Straps start at zero and change before a mid-run reset
`timescale 1ns/1ps
`default_nettype none
module isa_config_shared_memory_ctrl_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, r;
  logic [7:0] eeprom_config = 8'h00, memory_data_pins = 8'hA5, host_data_out;
  logic eeprom_config_enable = 1'b0, slot_width_pin = 1'b0;
  logic host_mem_cycle = 1'b0, host_mem_read = 1'b0;
  logic [23:0] host_addr = 24'h000000;
  logic [7:0] switch_config = 8'h00;
  logic buffer_select, boot_rom_read, host_data_oe, core_reset, core_clock_source;
  logic interrupt_drive_select, compat_map_select, soft_config_lock;
  int n_errors = 0, cmp_count = 0, cycles = 0;
  iscm_bank u_iscm_bank (.*);
  iscm_host u_iscm_host (.*);
  initial forever #20 aclk = ~aclk;
  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("Compares %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Host memory cycle, decoded outputs one cycle later
  task automatic host(input logic [23:0] a, input logic rdc, input logic bs, input logic bt);
    @(posedge aclk);
    {host_mem_cycle, host_addr, host_mem_read} <= {1'b1, a, rdc};
    repeat (2) @(posedge aclk);
    chk(buffer_select, bs);
    chk(boot_rom_read, bt);
    if (bt) chk({host_data_oe, host_data_out}, {1'b1, memory_data_pins});
    host_mem_cycle <= 1'b0;
  endtask
  // Upper config bits after settling
  task automatic cfg(input logic [3:0] e);
    repeat (3) @(posedge aclk);
    chk({soft_config_lock, core_clock_source, interrupt_drive_select, compat_map_select}, e);
  endtask
  task automatic t_slot();
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      slot_width_pin <= i[0];
      u_iscm_host.rd(4'h4, v);
      chk(v[0], i[0]);
    end
    chk(rresp, 2'h0);
    u_iscm_host.wr(4'h4, 8'hFF, r);
    chk(r, 2'h2);
    u_iscm_host.rd(4'h2, v);
    chk(v, 32'h0);
    chk(rresp, 2'h2);
    $display("t_slot done");
  endtask
  task automatic t_window();
    u_iscm_host.rd(4'h8, v);
    chk(v, 32'h0);
    u_iscm_host.wr(4'hC, 8'h01, r);
    chk(r, 2'h0);
    u_iscm_host.rd(4'hC, v);
    chk(v, 32'h01);
    u_iscm_host.wr(4'h8, 8'h05, r);
    host(24'h08A000, 1'b0, 1'b0, 1'b0);
    u_iscm_host.rd(4'h8, v);
    chk(v, 32'h05);
    u_iscm_host.wr(4'h8, 8'h45, r);
    host(24'h08A000, 1'b0, 1'b1, 1'b0);
    host(24'h08BFFF, 1'b1, 1'b1, 1'b0);
    host(24'h08C000, 1'b0, 1'b0, 1'b0);
    $display("t_window done");
  endtask
  task automatic t_config();
    u_iscm_host.wr(4'h0, 8'h0A, r);
    cfg(4'h0);
    host(24'h0C0010, 1'b1, 1'b0, 1'b1);
    u_iscm_host.wr(4'h0, 8'h7A, r);
    cfg(4'h7);
    u_iscm_host.wr(4'h0, 8'hFA, r);
    u_iscm_host.wr(4'h0, 8'h00, r);
    chk(r, 2'h2);
    cfg(4'hF);
    @(posedge aclk);
    {eeprom_config_enable, eeprom_config} <= {1'b1, 8'h40};
    cfg(4'h4);
    eeprom_config_enable <= 1'b0;
    $display("t_config done");
  endtask
  task automatic t_core();
    u_iscm_host.wr(4'h8, 8'h80, r);
    repeat (3) @(posedge aclk);
    chk(core_reset, 1'b1);
    repeat (8) @(posedge aclk);
    chk(core_reset, 1'b1);
    u_iscm_host.wr(4'h8, 8'h00, r);
    repeat (3) @(posedge aclk);
    chk(core_reset, 1'b0);
    $display("t_core done");
  endtask
  // Mid-run reset reloads the straps and clears the window
  task automatic t_reset();
    @(posedge aclk);
    switch_config <= 8'h3A;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    u_iscm_host.rd(4'h0, v);
    chk(v, 32'h3A);
    u_iscm_host.rd(4'h8, v);
    chk(v, 32'h0);
    $display("t_reset done");
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_slot();
    t_window();
    t_config();
    t_core();
    t_reset();
    test_done();
  end
endmodule // isa_config_shared_memory_ctrl_bench
`default_nettype wire
